// *** aovr_pkg.sv ***
// Purpose: Shared constants and types for the oversampling serial receiver
// Assumes: One core clock cycle is one oversampling clock cycle
// Notes:   Data bits are sent least significant bit first
`default_nettype none
package aovr_pkg;
	localparam int unsigned AOVR_DATA_W   = 8;
	localparam int unsigned AOVR_FIFO_D   = 16;
	// Clocking select value that selects asynchronous operation
	localparam logic        AOVR_ASYNC_SEL = 1'b0;
	// Oversampling cycles per bit and to mid-bit
	localparam logic [4:0]  AOVR_BIT16    = 5'h10;
	localparam logic [4:0]  AOVR_BIT8     = 5'h08;
	localparam logic [4:0]  AOVR_HALF16   = 5'h08;
	localparam logic [4:0]  AOVR_HALF8    = 5'h04;
	// Edge offsets from the expected edge, in oversampling cycles
	localparam logic [4:0]  AOVR_JITTER   = 5'h01;
	localparam logic [4:0]  AOVR_EARLY_HI = 5'h04;
	localparam logic [4:0]  AOVR_EARLY_LO = 5'h02;
	localparam logic [4:0]  AOVR_LATE_LO  = 5'h02;
	localparam logic [4:0]  AOVR_LATE_HI  = 5'h03;
	// Reset values
	localparam logic        AOVR_LINE_IDLE = 1'b1;
	localparam logic [4:0]  AOVR_CNT_RST  = 5'h00;

	typedef enum logic [1:0] {
		AOVR_IDLE  = 2'b00,
		AOVR_START = 2'b01,
		AOVR_BITS  = 2'b10
	} aovr_state_t;

	typedef struct packed {
		logic [AOVR_DATA_W-1:0] data;
		logic                   parity_err;
		logic                   frame_err;
	} aovr_char_t;
endpackage
`default_nettype wire

// *** aovr_receiver.sv ***
// Purpose: Oversampling asynchronous receiver with character FIFO
// Assumes: Mode inputs are static while a character is being received
// Notes:   A character that finds the FIFO full is dropped, o_overrun pulses
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module aovr_fifo #(
	parameter int unsigned WIDTH = 10,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push, pop;

	always_comb begin
		o_in_ready     = (count != (AW+1)'(DEPTH));
		push           = i_in_valid && o_in_ready;
		pop            = (count != '0) && (!o_out_valid || i_out_ready);
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
		next_out_valid = pop ? 1'b1 : (o_out_valid && !i_out_ready);
		next_out_data  = pop ? mem[rd_ptr] : o_out_data;
	end

	// Output held in a register so the top sees a flip-flop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			o_out_valid <= 1'b0;
			o_out_data  <= '0;
		end else begin
			wr_ptr      <= next_wr_ptr;
			rd_ptr      <= next_rd_ptr;
			count       <= next_count;
			o_out_valid <= next_out_valid;
			o_out_data  <= next_out_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Clocking select 0 makes the receiver oversample the serial input.
// - Sample rate select picks 16x or 8x oversampling of the baud rate.
// - Start bit recognised after input stays low for half a bit period.
// - After start, data bits, then parity if enabled, then stop are sampled in turn.
// - In 16x mode start on eighth low sample; bits last 16 cycles.
// - In 8x mode start on fourth low sample; bits last 8 cycles.
// - Drift compensation works only in 16x mode; 8x never adjusts.
// - Drift compensation stays off unless its enable bit is set.
// - Edge within one cycle of expected place is jitter; no change.
// - Edge 4 to 2 cycles early shortens current bit by one cycle.
// - Edge 2 to 3 cycles late lengthens current bit by one cycle.
module aovr_receiver import aovr_pkg::*; (
	input  wire logic  i_core_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_rxd,
	input  wire logic  i_clk_select,
	input  wire logic  i_rate_select,
	input  wire logic  i_drift_en,
	input  wire logic  i_parity_en,
	input  wire logic  i_parity_odd,
	output aovr_char_t o_char,
	output logic       o_char_valid,
	input  wire logic  i_char_ready,
	output logic       o_overrun
);
	logic        rst_ff1, rst_ff2, rst_n;
	logic        rx_ff1, rx_ff2, rx_ff3, rx_level, rx_prev, next_rx_level;
	aovr_state_t state, next_state;
	logic [4:0]  cnt, next_cnt, period_end, next_period_end;
	logic [3:0]  bit_idx, next_bit_idx;
	logic [AOVR_DATA_W-1:0] shreg, next_shreg;
	logic        par_acc, next_par_acc, par_err, next_par_err;
	logic        push, next_push, next_overrun;
	aovr_char_t  push_char, next_push_char;
	logic        fifo_ready;
	logic [4:0]  blen, half;
	logic        edge_seen, sample, drift_on, stop_bit;

	function automatic logic [4:0] bit_len(input logic rate8);
		return rate8 ? AOVR_BIT8 : AOVR_BIT16;
	endfunction

	function automatic logic [4:0] half_len(input logic rate8);
		return rate8 ? AOVR_HALF8 : AOVR_HALF16;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchroniser
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_ff1 <= 1'b0;
			rst_ff2 <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_ff2 <= rst_ff1;
		end
	end
	assign rst_n = rst_ff2;

	// Level moves only when the last two stages agree, filtering glitches
	always_comb begin
		next_rx_level = (rx_ff2 == rx_ff3) ? rx_ff3 : rx_level;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ff1   <= AOVR_LINE_IDLE;
			rx_ff2   <= AOVR_LINE_IDLE;
			rx_ff3   <= AOVR_LINE_IDLE;
			rx_level <= AOVR_LINE_IDLE;
			rx_prev  <= AOVR_LINE_IDLE;
		end else begin
			rx_ff1   <= i_rxd;
			rx_ff2   <= rx_ff1;
			rx_ff3   <= rx_ff2;
			rx_level <= next_rx_level;
			rx_prev  <= rx_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive state machine
	always_comb begin
		blen            = bit_len(i_rate_select);
		half            = half_len(i_rate_select);
		edge_seen       = (rx_level != rx_prev);
		drift_on        = !i_rate_select && i_drift_en;
		sample          = (state == AOVR_BITS) && (cnt == period_end);
		stop_bit        = (bit_idx == 4'(AOVR_DATA_W) + 4'(i_parity_en));
		next_state      = state;
		next_cnt        = cnt;
		next_period_end = period_end;
		next_bit_idx    = bit_idx;
		next_shreg      = shreg;
		next_par_acc    = par_acc;
		next_par_err    = par_err;
		next_push       = 1'b0;
		next_push_char  = push_char;
		next_overrun    = push && !fifo_ready;
		unique case (state)
			AOVR_IDLE: begin
				if (i_clk_select == AOVR_ASYNC_SEL && !rx_level) begin
					next_state = AOVR_START;
					next_cnt   = 5'h01;
				end
			end
			AOVR_START: begin
				if (rx_level) begin
					next_state = AOVR_IDLE;
				end else if (cnt + 5'h01 == half) begin
					next_state      = AOVR_BITS;
					next_cnt        = AOVR_CNT_RST;
					next_period_end = blen - 5'h01;
					next_bit_idx    = '0;
					next_par_acc    = i_parity_odd;
					next_par_err    = 1'b0;
				end else begin
					next_cnt = cnt + 5'h01;
				end
			end
			AOVR_BITS: begin
				next_cnt = cnt + 5'h01;
				// Only one correction per bit; edges near mid are jitter
				if (edge_seen && drift_on && period_end == blen - 5'h01) begin
					if (cnt >= half - AOVR_EARLY_HI &&
					    cnt <= half - AOVR_EARLY_LO) begin
						next_period_end = blen - 5'h02;
					end else if (cnt >= half + AOVR_LATE_LO &&
					             cnt <= half + AOVR_LATE_HI) begin
						next_period_end = blen;
					end
				end
				if (sample) begin
					next_cnt        = AOVR_CNT_RST;
					next_period_end = blen - 5'h01;
					next_bit_idx    = bit_idx + 4'h1;
					if (bit_idx < 4'(AOVR_DATA_W)) begin
						next_shreg   = {rx_level, shreg[AOVR_DATA_W-1:1]};
						next_par_acc = par_acc ^ rx_level;
					end else if (!stop_bit) begin
						next_par_err = par_acc ^ rx_level;
					end else begin
						next_state = AOVR_IDLE;
						next_push  = 1'b1;
						next_push_char.data       = shreg;
						next_push_char.parity_err = par_err;
						next_push_char.frame_err  = !rx_level;
					end
				end
			end
			default: begin
				next_state = AOVR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= AOVR_IDLE;
			cnt        <= AOVR_CNT_RST;
			period_end <= AOVR_BIT16 - 5'h01;
			bit_idx    <= '0;
			shreg      <= '0;
			par_acc    <= 1'b0;
			par_err    <= 1'b0;
			push       <= 1'b0;
			push_char  <= '0;
			o_overrun  <= 1'b0;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			period_end <= next_period_end;
			bit_idx    <= next_bit_idx;
			shreg      <= next_shreg;
			par_acc    <= next_par_acc;
			par_err    <= next_par_err;
			push       <= next_push;
			push_char  <= next_push_char;
			o_overrun  <= next_overrun;
		end
	end

	// A serial line cannot be paused, so a full FIFO costs the character
	aovr_fifo #(
		.WIDTH ($bits(aovr_char_t)),
		.DEPTH (AOVR_FIFO_D)
	) u_fifo (
		.i_clk       (i_core_clk),
		.i_rst_n     (rst_n),
		.i_in_valid  (push),
		.i_in_data   (push_char),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_char_valid),
		.o_out_data  (o_char),
		.i_out_ready (i_char_ready)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [4:0] low_run;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_run <= AOVR_CNT_RST;
		end else begin
			low_run <= rx_level ? 5'h00 : ((low_run == 5'h1f) ? low_run
			           : low_run + 5'h01);
		end
	end

	a_start_half: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_START && next_state == AOVR_BITS)
		|-> (low_run + 5'h01 == half))
		else $error("start accepted without half a bit of low");
	a_start_16: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_IDLE && !rx_level && !i_rate_select && !i_clk_select)
		##1 (!rx_level && state == AOVR_START) [*7] |=> state == AOVR_BITS)
		else $error("16x start not on eighth low sample");
	a_start_8: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_IDLE && !rx_level && i_rate_select && !i_clk_select)
		##1 (!rx_level && state == AOVR_START) [*3] |=> state == AOVR_BITS)
		else $error("8x start not on fourth low sample");
	a_sync_idle: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_IDLE && i_clk_select != AOVR_ASYNC_SEL)
		|=> state == AOVR_IDLE)
		else $error("receiver left idle in synchronous mode");
	a_bit_16: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(sample && next_state == AOVR_BITS && !i_rate_select && !i_drift_en)
		|-> ##16 sample)
		else $error("16x bit did not last 16 cycles");
	a_bit_8: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(sample && next_state == AOVR_BITS && i_rate_select)
		|=> !sample [*7] ##1 sample)
		else $error("8x bit did not last 8 cycles");
	a_no_drift8: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_BITS && i_rate_select) |-> period_end == AOVR_BIT8 - 5'h01)
		else $error("bit period adjusted in 8x mode");
	a_drift_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_BITS && !i_drift_en) |-> period_end == blen - 5'h01)
		else $error("bit period adjusted with drift disabled");
	a_jitter: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_BITS && edge_seen && !sample && cnt >= half - AOVR_JITTER
		 && cnt <= half + AOVR_JITTER && period_end == blen - 5'h01)
		|=> period_end == blen - 5'h01)
		else $error("jitter edge changed the bit period");
	a_shorten: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_BITS && edge_seen && drift_on && !sample
		 && period_end == AOVR_BIT16 - 5'h01
		 && cnt >= AOVR_HALF16 - AOVR_EARLY_HI && cnt <= AOVR_HALF16 - AOVR_EARLY_LO)
		|=> period_end == AOVR_BIT16 - 5'h02)
		else $error("early edge did not shorten the bit");
	a_lengthen: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		(state == AOVR_BITS && edge_seen && drift_on && !sample
		 && period_end == AOVR_BIT16 - 5'h01
		 && cnt >= AOVR_HALF16 + AOVR_LATE_LO && cnt <= AOVR_HALF16 + AOVR_LATE_HI)
		|=> period_end == AOVR_BIT16)
		else $error("late edge did not lengthen the bit");
	a_stop_last: assert property (@(posedge i_core_clk) disable iff (!rst_n)
		push |-> $past(sample) && $past(stop_bit) && state == AOVR_IDLE)
		else $error("character pushed before its stop bit");
endmodule
`default_nettype wire

// *** aovr_tx_model.sv ***
// Purpose: Remote serial transmitter driving the receiver's input line
// Assumes: Caller enters each task just after a rising clock edge
// Notes:   Line idles high; bit length is given per frame in clock cycles
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module aovr_tx_model (
	input  wire logic i_clk,
	output var logic  o_line
);
	initial o_line = 1'b1;

	task automatic put(input logic v, input int n);
		o_line <= v;
		repeat (n) @(posedge i_clk);
	endtask

	// A low stop is cut short so its tail cannot pass for a new start
	task automatic send(input logic [7:0] d, input logic pen,
			input logic odd, input logic bad, input int len,
			input logic stop);
		put(1'b0, len);
		for (int i = 0; i < 8; i++) begin
			put(d[i], len);
		end
		if (pen) begin
			put(^d ^ odd ^ bad, len);
		end
		put(stop, stop ? len : len / 2 + 2);
		put(1'b1, 2 * len);
	endtask
endmodule
`default_nettype wire

// *** async_oversampling_receiver_test.sv ***
// Purpose: Self-checking bench for the oversampling receiver
// Assumes: Transmitter model drives the line, bench takes characters
// Notes:   Characters are queued by a monitor and compared in order
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module async_oversampling_receiver_test import aovr_pkg::*;;
	logic       i_core_clk;
	logic       i_rst_n;
	logic       sel;
	logic       rate;
	logic       drift;
	logic       pen;
	logic       podd;
	logic       ready;
	wire logic  rxd;
	aovr_char_t ch;
	logic       valid;
	logic       ovr;
	int         failures;
	int         num_checks;
	int         ovr_cnt;
	int         cyc;
	aovr_char_t q[$];

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	aovr_tx_model i_tx (.i_clk(i_core_clk), .o_line(rxd));

	aovr_receiver i_dut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rxd(rxd),
		.i_clk_select(sel), .i_rate_select(rate), .i_drift_en(drift),
		.i_parity_en(pen), .i_parity_odd(podd), .o_char(ch),
		.o_char_valid(valid), .i_char_ready(ready), .o_overrun(ovr)
	);

	always @(posedge i_core_clk) begin
		if (valid === 1'b1 && ready === 1'b1) q.push_back(ch);
		if (ovr === 1'b1) ovr_cnt++;
		cyc++;
		if (cyc == 30000) begin
			failures++;
			$display("wrong value at %0t: run hung", $time);
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input aovr_char_t e);
		int n;
		n = 0;
		while (q.size() == 0 && n < 400) begin
			@(posedge i_core_clk);
			n++;
		end
		num_checks++;
		if (q.size() == 0 || q[0] !== e) begin
			failures++;
			$display("wrong value at %0t: want %h", $time, e);
		end
		if (q.size() != 0) void'(q.pop_front());
	endtask

	task automatic chk_int(input int got, input int want);
		num_checks++;
		if (got != want) begin
			failures++;
			$display("wrong value at %0t: got %0d want %0d", $time, got, want);
		end
	endtask

	task automatic mode(input logic r, input logic d, input logic p,
			input logic o);
		@(posedge i_core_clk);
		rate <= r;
		drift <= d;
		pen <= p;
		podd <= o;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_rates();
		logic [7:0] dv[3] = '{8'hA5, 8'h01, 8'hFE};
		for (int m = 0; m < 4; m++) begin
			mode(m[1], 1'b0, 1'b1, m[0]);
			for (int i = 0; i < 3; i++) begin
				i_tx.send(dv[i], 1'b1, m[0], 1'b0, m[1] ? 8 : 16, 1'b1);
				chk({dv[i], 2'b00});
			end
		end
		$display("test rates done");
	endtask

	task automatic t_errors();
		mode(1'b0, 1'b0, 1'b1, 1'b0);
		i_tx.send(8'h3C, 1'b1, 1'b0, 1'b1, 16, 1'b1);
		chk({8'h3C, 2'b10});
		i_tx.send(8'hC3, 1'b1, 1'b0, 1'b0, 16, 1'b0);
		chk({8'hC3, 2'b01});
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		i_tx.send(8'h69, 1'b0, 1'b0, 1'b0, 8, 1'b1);
		chk({8'h69, 2'b00});
		$display("test errors done");
	endtask

	// Short lows and a disabled receiver must both leave nothing behind
	task automatic t_refuse();
		mode(1'b0, 1'b0, 1'b0, 1'b0);
		i_tx.put(1'b0, 6);
		i_tx.put(1'b1, 40);
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		i_tx.put(1'b0, 2);
		i_tx.put(1'b1, 40);
		chk_int(q.size(), 0);
		sel <= 1'b1;
		i_tx.send(8'h55, 1'b0, 1'b0, 1'b0, 8, 1'b1);
		chk_int(q.size(), 0);
		sel <= AOVR_ASYNC_SEL;
		$display("test refuse done");
	endtask

	task automatic t_drift();
		mode(1'b0, 1'b1, 1'b1, 1'b1);
		i_tx.send(8'h96, 1'b1, 1'b1, 1'b0, 15, 1'b1);
		chk({8'h96, 2'b00});
		i_tx.send(8'h69, 1'b1, 1'b1, 1'b0, 17, 1'b1);
		chk({8'h69, 2'b00});
		i_tx.send(8'h0F, 1'b1, 1'b1, 1'b0, 16, 1'b1);
		chk({8'h0F, 2'b00});
		mode(1'b1, 1'b1, 1'b1, 1'b1);
		i_tx.send(8'hF0, 1'b1, 1'b1, 1'b0, 8, 1'b1);
		chk({8'hF0, 2'b00});
		$display("test drift done");
	endtask

	// Depth is the FIFO plus the output register; one more is dropped
	task automatic t_fifo();
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		ready <= 1'b0;
		ovr_cnt = 0;
		for (int i = 0; i < AOVR_FIFO_D + 2; i++) begin
			i_tx.send(8'(i), 1'b0, 1'b0, 1'b0, 8, 1'b1);
		end
		chk_int(ovr_cnt, 1);
		ready <= 1'b1;
		for (int i = 0; i < AOVR_FIFO_D + 1; i++) begin
			chk({8'(i), 2'b00});
		end
		repeat (20) @(posedge i_core_clk);
		chk_int(q.size(), 0);
		$display("test fifo done");
	endtask

	initial begin
		i_rst_n = 1'b0;
		sel = AOVR_ASYNC_SEL;
		rate = 1'b0;
		drift = 1'b0;
		pen = 1'b0;
		podd = 1'b0;
		ready = 1'b1;
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		t_rates();
		t_errors();
		t_refuse();
		t_drift();
		t_fifo();
		print_verdict();
	end
endmodule
`default_nettype wire
